// ### lrt_lockin_timing.sv
// Purpose: Reference timing, rephasing and loop control of the lock-in.
// Assumes: err_in and nv_load_data come from logic on the same clock.
// Notes: The 1.048576 MHz reference is an enable from a phase
// accumulator, so single ticks jitter by one system clock.
`timescale 1ns/1ps
// How it works
// - Demod reference is 32.768 kHz, cut from the single reference tick.
// - In f mode the modulation channel follows the demod rate exactly.
// - In 2f mode the modulation channel runs at half that rate.
// - Modulation frequency writes are ignored while a harmonic mode runs.
// - Active at power-up: slip modulation phase until it equals stored phase.
// - Mode off frees modulation frequency and skips startup rephasing.
// - Any demod mode change other than to off starts rephasing again.
// - Phase-ready flag rises only after rephasing completes.
// - Loop mode picks proportional or proportional plus integral.
// - Laser correction drives only when lock and modulation enable set.
// - Filter enable inserts a low-pass stage with selectable corner.
// - First-stage gain held within 0 to 80 dB, direct or stepped.
// - Monitor output shows correction or loop error by selection.
// - Input offset held within -500 to 500 mV.
// - Save stores all settings except modulation frequency; power-up loads them as defaults.
// - Filter clock derives from the 1.048576 MHz reference.
// - Reference divided by eight gives the 131.072 kHz sample tick.
// - Band-pass choices: eighth, quarter narrow and quarter wide.
// - Low-pass fifth and eighth, quarter notch and all-pass choices.
// - Exactly one filter response is selected at a time.
// - Unit stays idle while another locking unit is active.
module lrt_lockin_timing #(
    parameter int SETTLE_CYCLES = 200000000
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic other_lock_active,
    input wire logic signed [15:0] err_in,
    input wire logic [lrt_pkg::NV_W-1:0] nv_load_data,
    output logic nv_store,
    output logic [lrt_pkg::NV_W-1:0] nv_store_data,
    output logic ref_clk_en,
    output logic sample_clk_en,
    output logic demod_ref,
    output logic mod_ref,
    output logic [2:0] filt_select,
    output logic [6:0] vga_gain_db,
    output logic signed [15:0] laser_corr,
    output logic laser_drive,
    output logic signed [15:0] monitor_out,
    output logic phase_ready
);
    import lrt_pkg::*;

    typedef enum logic [2:0] {
        ST_BOOT, ST_OFF, ST_ALIGN, ST_SETTLE, ST_READY
    } lrt_state_type;

    ////////////////////////////////////////////////////////////////////
    logic [1:0] mode_q;
    logic pi_q, lock_q, moden_q, filten_q, monerr_q;
    logic [31:0] modfreq_q;
    logic [PH_W-1:0] phase_q;
    logic [6:0] gain_q;
    logic signed [15:0] ofs_q;
    logic [2:0] filt_q;
    logic [3:0] corner_q;
    logic [7:0] prop_q;
    logic [3:0] integ_q;
    logic save_q;
    logic boot_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic wr;
    logic [31:0] wd;
    logic signed [15:0] wofs;

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;

    // Byte lanes merge into the given value; only modfreq_q keeps old bytes on partial writes.
    function automatic logic [31:0] merge(input logic [31:0] old);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
                r[b*8 +: 8] = wb_dat_i[b*8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        wd = merge(32'h0);
        wofs = $signed(wd[15:0]);
    end

    ////////////////////////////////////////////////////////////////////
    // Control registers; the first cycle after reset loads the saved
    // image, so software writes never race the power-up defaults.
    always_ff @(posedge clock) begin
        if (reset) begin
            boot_q <= 1'b1;
            mode_q <= DM_OFF;
            pi_q <= 1'b0;
            lock_q <= 1'b0;
            moden_q <= 1'b0;
            filten_q <= 1'b0;
            monerr_q <= 1'b0;
            modfreq_q <= 32'h0;
            phase_q <= '0;
            filt_q <= F_ALLPASS;
            corner_q <= 4'h0;
            prop_q <= 8'h10;
            integ_q <= 4'h8;
            save_q <= 1'b0;
        end else if (boot_q) begin
            boot_q <= 1'b0;
            {integ_q, prop_q, phase_q, corner_q, filt_q} <=
                nv_load_data[NV_W-1:30];
            {monerr_q, filten_q, moden_q, lock_q, pi_q, mode_q} <=
                nv_load_data[6:0];
        end else begin
            save_q <= wr && (wb_adr_i == A_CTRL) && wd[C_SAVE];
            if (wr && wb_adr_i == A_CTRL) begin
                mode_q <= wd[C_MODE +: 2];
                pi_q <= wd[C_PI];
                lock_q <= wd[C_LOCK];
                moden_q <= wd[C_MODEN];
                filten_q <= wd[C_FILTEN];
                monerr_q <= wd[C_MONERR];
            end else if (wr && wb_adr_i == A_MODFREQ) begin
                if (mode_q == DM_OFF) begin
                    modfreq_q <= merge(modfreq_q);
                end
            end else if (wr && wb_adr_i == A_PHASE) begin
                phase_q <= wd[PH_W-1:0];
            end else if (wr && wb_adr_i == A_FILT) begin
                if (wd[2:0] <= F_ALLPASS) begin
                    filt_q <= wd[2:0];
                end
                corner_q <= wd[11:8];
            end else if (wr && wb_adr_i == A_LOOP) begin
                prop_q <= wd[7:0];
                integ_q <= wd[11:8];
            end
        end
    end

    // Gain and offset are clamped on entry rather than rejected.
    always_ff @(posedge clock) begin
        if (reset) begin
            gain_q <= 7'h0;
            ofs_q <= 16'sh0;
        end else if (boot_q) begin
            gain_q <= nv_load_data[13:7];
            ofs_q <= $signed(nv_load_data[29:14]);
        end else if (wr && wb_adr_i == A_GAIN) begin
            gain_q <= (wd[7:0] > 8'(GAIN_MAX_DB)) ? GAIN_MAX_DB
                                                  : wd[6:0];
        end else if (wr && wb_adr_i == A_STEP) begin
            if (wd[0] && gain_q < GAIN_MAX_DB) begin
                gain_q <= gain_q + 7'h1;
            end else if (wd[1] && gain_q != 7'h0) begin
                gain_q <= gain_q - 7'h1;
            end
        end else if (wr && wb_adr_i == A_OFFSET) begin
            if (wofs > OFS_MAX_MV) begin
                ofs_q <= OFS_MAX_MV;
            end else if (wofs < OFS_MIN_MV) begin
                ofs_q <= OFS_MIN_MV;
            end else begin
                ofs_q <= wofs;
            end
        end
    end

    assign nv_store = save_q;
    assign nv_store_data = {integ_q, prop_q, phase_q, corner_q, filt_q,
        ofs_q, gain_q, monerr_q, filten_q, moden_q, lock_q, pi_q,
        mode_q};
    assign vga_gain_db = gain_q;
    assign filt_select = filt_q;

    ////////////////////////////////////////////////////////////////////
    // Single timing source: every reference edge comes from ref_acc, except mod_ref outside f and 2f modes.
    logic [31:0] ref_acc_q;
    logic ref_tick_q;
    logic [2:0] samp_cnt_q;
    logic samp_q;
    logic [PH_W-1:0] ref_cnt_q;
    logic [PH_W-1:0] mod_cnt_q;
    logic [31:0] mod_acc_q;
    logic [32:0] ref_sum;
    logic slip;

    assign ref_sum = {1'b0, ref_acc_q} + {1'b0, REF_INC};

    always_ff @(posedge clock) begin
        if (reset) begin
            ref_acc_q <= 32'h0;
            ref_tick_q <= 1'b0;
        end else begin
            ref_acc_q <= ref_sum[31:0];
            ref_tick_q <= ref_sum[32];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            samp_cnt_q <= 3'h0;
            samp_q <= 1'b0;
        end else begin
            samp_q <= ref_tick_q && samp_cnt_q == SAMPLE_LAST;
            if (ref_tick_q) begin
                samp_cnt_q <= samp_cnt_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ref_cnt_q <= '0;
            mod_cnt_q <= '0;
        end else if (ref_tick_q) begin
            ref_cnt_q <= ref_cnt_q + 6'h1;
            if (!slip) begin
                mod_cnt_q <= mod_cnt_q + 6'h1;
            end
        end
    end

    // Free-running channel used only when the mode is off or reserved.
    always_ff @(posedge clock) begin
        if (reset) begin
            mod_acc_q <= 32'h0;
        end else begin
            mod_acc_q <= mod_acc_q + modfreq_q;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            demod_ref <= 1'b0;
            mod_ref <= 1'b0;
        end else begin
            demod_ref <= ref_cnt_q[4];
            if (mode_q == DM_1F) begin
                mod_ref <= mod_cnt_q[4];
            end else if (mode_q == DM_2F) begin
                mod_ref <= mod_cnt_q[5];
            end else begin
                mod_ref <= mod_acc_q[31];
            end
        end
    end

    assign ref_clk_en = ref_tick_q;
    assign sample_clk_en = samp_q;

    ////////////////////////////////////////////////////////////////////
    lrt_state_type st_q;
    logic [1:0] mode_seen_q;
    logic [31:0] settle_q;
    logic [PH_W-1:0] ph_diff, ph_mask;
    logic aligned;

    assign ph_mask = (mode_q == DM_2F) ? PH_MASK_2F : PH_MASK_1F;
    assign ph_diff = mod_cnt_q - ref_cnt_q;
    assign aligned = ((ph_diff ^ phase_q) & ph_mask) == '0;
    // Holding the channel one tick shifts its phase by one step.
    assign slip = (st_q == ST_ALIGN) && !aligned;

    always_ff @(posedge clock) begin
        if (reset) begin
            st_q <= ST_BOOT;
            mode_seen_q <= DM_OFF;
            settle_q <= 32'h0;
        end else begin
            mode_seen_q <= mode_q;
            case (st_q)
                ST_BOOT: begin
                    if (!boot_q) begin
                        st_q <= ST_OFF;
                        if (mode_q != DM_OFF) begin
                            st_q <= ST_ALIGN;
                        end
                    end
                end
                ST_ALIGN: begin
                    settle_q <= 32'h0;
                    if (ref_tick_q && aligned) begin
                        st_q <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    settle_q <= settle_q + 32'h1;
                    if (settle_q >= 32'(SETTLE_CYCLES - 1)) begin
                        st_q <= ST_READY;
                    end
                end
                default: begin
                end
            endcase
            if (st_q != ST_BOOT && mode_q != mode_seen_q) begin
                st_q <= (mode_q == DM_OFF) ? ST_OFF
                                           : ST_ALIGN;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            phase_ready <= 1'b0;
        end else begin
            phase_ready <= (st_q == ST_READY) &&
                (mode_q == mode_seen_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Loop arithmetic runs once per sample tick at 32-bit width and
    // saturates to 16 bits, trading range for a fixed output scale.
    logic signed [31:0] err_q, integ_acc_q, lp_q, corr;
    logic signed [15:0] corr_sat;
    logic unit_on;

    function automatic logic signed [15:0] sat(
        input logic signed [31:0] v);
        logic signed [15:0] r;
        r = v[15:0];
        if (v > 32'(OUT_MAX)) begin
            r = OUT_MAX;
        end else if (v < 32'(OUT_MIN)) begin
            r = OUT_MIN;
        end
        return r;
    endfunction

    assign unit_on = (mode_q != DM_OFF) && !other_lock_active;

    always_ff @(posedge clock) begin
        if (reset) begin
            err_q <= 32'sh0;
            integ_acc_q <= 32'sh0;
        end else if (samp_q) begin
            err_q <= 32'(err_in) - 32'(ofs_q);
            if (pi_q && lock_q && unit_on) begin
                integ_acc_q <= 32'(sat(integ_acc_q +
                    (err_q >>> integ_q)));
            end else begin
                integ_acc_q <= 32'sh0;
            end
        end
    end

    assign corr = ((err_q * $signed({24'h0, prop_q})) >>> 4) +
        integ_acc_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            lp_q <= 32'sh0;
        end else if (samp_q) begin
            lp_q <= lp_q + ((32'(sat(corr)) - lp_q) >>> corner_q);
        end
    end

    assign corr_sat = filten_q ? sat(lp_q) : sat(corr);

    always_ff @(posedge clock) begin
        if (reset) begin
            laser_corr <= 16'sh0;
            laser_drive <= 1'b0;
            monitor_out <= 16'sh0;
        end else begin
            laser_drive <= lock_q && moden_q && unit_on;
            laser_corr <= (lock_q && moden_q && unit_on) ? corr_sat
                                                         : 16'sh0;
            monitor_out <= monerr_q ? sat(err_q) : corr_sat;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Wishbone classic: ack one cycle after the strobe, for any address.
    always_ff @(posedge clock) begin
        if (reset) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
            if (wb_adr_i == A_CTRL) begin
                rdat_q <= {25'h0, monerr_q, filten_q, moden_q, lock_q,
                    pi_q, mode_q};
            end else if (wb_adr_i == A_MODFREQ) begin
                rdat_q <= modfreq_q;
            end else if (wb_adr_i == A_PHASE) begin
                rdat_q <= {26'h0, phase_q};
            end else if (wb_adr_i == A_GAIN) begin
                rdat_q <= {25'h0, gain_q};
            end else if (wb_adr_i == A_OFFSET) begin
                rdat_q <= {{16{ofs_q[15]}}, ofs_q};
            end else if (wb_adr_i == A_FILT) begin
                rdat_q <= {20'h0, corner_q, 5'h0, filt_q};
            end else if (wb_adr_i == A_STATUS) begin
                rdat_q <= {26'h0, other_lock_active, mod_ref, demod_ref,
                    (st_q == ST_ALIGN || st_q == ST_SETTLE), 1'b0,
                    phase_ready};
            end else if (wb_adr_i == A_LOOP) begin
                rdat_q <= {20'h0, integ_q, prop_q};
            end else begin
                rdat_q <= 32'h0;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
endmodule

// ### lrt_pkg.sv
// Purpose: Shared constants and types for the lock-in reference timing.
// Assumes: 200 MHz system clock, Wishbone classic register access.
// Notes: Offsets are byte addresses of 32-bit registers.
package lrt_pkg;
    localparam longint CLK_HZ = 200000000;
    localparam longint REF_HZ = 1048576;
    localparam longint DEMOD_HZ = 32768;
    // Phase step of the reference oscillator, 32-bit accumulator.
    localparam logic [31:0] REF_INC =
        32'((REF_HZ << 32) / CLK_HZ);
    localparam int SAMPLE_DIV = int'(REF_HZ / 131072);
    localparam int DEMOD_DIV = int'(REF_HZ / DEMOD_HZ);
    localparam logic [2:0] SAMPLE_LAST = 3'(SAMPLE_DIV - 1);
    localparam int PH_W = 6;
    localparam logic [PH_W-1:0] PH_MASK_1F = 6'h1f;
    localparam logic [PH_W-1:0] PH_MASK_2F = 6'h3f;

    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_MODFREQ = 8'h04;
    localparam logic [7:0] A_PHASE = 8'h08;
    localparam logic [7:0] A_GAIN = 8'h0c;
    localparam logic [7:0] A_STEP = 8'h10;
    localparam logic [7:0] A_OFFSET = 8'h14;
    localparam logic [7:0] A_FILT = 8'h18;
    localparam logic [7:0] A_STATUS = 8'h1c;
    localparam logic [7:0] A_LOOP = 8'h20;

    localparam int C_MODE = 0;
    localparam int C_PI = 2;
    localparam int C_LOCK = 3;
    localparam int C_MODEN = 4;
    localparam int C_FILTEN = 5;
    localparam int C_MONERR = 6;
    localparam int C_SAVE = 7;

    localparam logic [6:0] GAIN_MAX_DB = 7'h50;
    localparam logic signed [15:0] OFS_MAX_MV = 16'sh01f4;
    localparam logic signed [15:0] OFS_MIN_MV = -16'sh01f4;
    localparam logic signed [15:0] OUT_MAX = 16'sh7fff;
    localparam logic signed [15:0] OUT_MIN = -16'sh7fff;

    typedef enum logic [1:0] {
        DM_OFF, DM_1F, DM_2F, DM_RSV
    } lrt_dmode_type;

    typedef enum logic [2:0] {
        F_BANDPASS_EIGHTH, F_BANDPASS_QUARTER_NARROW,
        F_BANDPASS_QUARTER_WIDE, F_LOWPASS_FIFTH,
        F_LOWPASS_EIGHTH, F_NOTCH_QUARTER, F_ALLPASS
    } lrt_filt_type;

    // Nonvolatile image: loop 12, phase 6, corner 4, filter 3,
    // offset 16, gain 7, control 7.
    localparam int NV_W = 55;
endpackage

// ### lrt_lockin_timing_sva.sv
// Purpose: Concurrent checks on the lock-in reference timing ports.
// Assumes: One clock domain; synchronous active-high reset.
// Notes: Rate checks start only after a first reference tick is seen.
`timescale 1ns/1ps
module lrt_lockin_timing_chk (
    input wire logic clock,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic other_lock_active,
    input wire logic nv_store,
    input wire logic ref_clk_en,
    input wire logic sample_clk_en,
    input wire logic demod_ref,
    input wire logic [2:0] filt_select,
    input wire logic [6:0] vga_gain_db,
    input wire logic signed [15:0] laser_corr,
    input wire logic laser_drive
);
    import lrt_pkg::*;
    logic [7:0] gap_q;
    logic [3:0] smp_q;
    logic [4:0] half_q;
    logic dm_q;
    logic seen_q;
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    // Sample and half-period windows count ticks since the last event, so a one-cycle offset
    // between registered enables cannot change the total; the gap window counts clocks.
    always_ff @(posedge clock) begin
        if (reset) begin
            gap_q <= 8'h00;
            smp_q <= 4'h0;
            half_q <= 5'h00;
            dm_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            gap_q <= ref_clk_en ? 8'h01 : gap_q + 8'(gap_q != 8'hff);
            smp_q <= sample_clk_en ? 4'(ref_clk_en) : smp_q + 4'(ref_clk_en);
            half_q <= (demod_ref != dm_q) ? 5'(ref_clk_en)
                : half_q + 5'(ref_clk_en);
            dm_q <= demod_ref;
            seen_q <= seen_q | ref_clk_en;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    ref_gap_a: assert property (ref_clk_en && seen_q |->
        gap_q inside {8'd190, 8'd191}) else $error("reference tick gap");
    sample_div_a: assert property (sample_clk_en && seen_q |->
        smp_q + 4'(ref_clk_en) == 4'd8) else $error("sample divide");
    demod_half_a: assert property (demod_ref != dm_q && seen_q |->
        half_q + 5'(ref_clk_en) == 5'd16) else $error("demod half period");
    ack_once_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack timing");
    save_pulse_a: assert property (wb_cyc_i && wb_stb_i && wb_we_i &&
        !wb_ack_o && wb_adr_i == A_CTRL && wb_sel_i[0] && wb_dat_i[C_SAVE]
        |-> ##1 nv_store ##1 !nv_store) else $error("save pulse");
    drive_zero_a: assert property (!laser_drive && !$past(laser_drive)
        |-> laser_corr == 16'sh0000) else $error("correction while idle");
    other_idle_a: assert property (other_lock_active [*2]
        |-> !laser_drive) else $error("drive with other lock");
    gain_limit_a: assert property (vga_gain_db <= GAIN_MAX_DB)
        else $error("gain above limit");
    filt_code_a: assert property (filt_select != 3'h7)
        else $error("filter code invalid");
endmodule
bind lrt_lockin_timing lrt_lockin_timing_chk u_chk (.clock(clock),
    .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .other_lock_active(other_lock_active), .nv_store(nv_store),
    .ref_clk_en(ref_clk_en), .sample_clk_en(sample_clk_en),
    .demod_ref(demod_ref), .filt_select(filt_select),
    .vga_gain_db(vga_gain_db), .laser_corr(laser_corr),
    .laser_drive(laser_drive));

// ### lrt_far_model.sv
// Purpose: Detector and laser current path beside the lock-in block.
// Assumes: The detector error is refreshed on filter sample ticks.
// Notes: The error level is set by the bench.
`timescale 1ns/1ps
module lrt_far_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic sample_clk_en,
    input wire logic signed [15:0] err_level,
    input wire logic laser_drive,
    input wire logic signed [15:0] laser_corr,
    output logic signed [15:0] err_in,
    output logic signed [15:0] laser_seen
);
    always_ff @(posedge clock) begin
        if (reset) begin
            err_in <= 16'sh0000;
        end else if (sample_clk_en) begin
            err_in <= err_level;
        end
    end
    // An undriven actuator carries no current, so the tap reads zero.
    assign laser_seen = laser_drive ? laser_corr : 16'sh0000;
endmodule

// ### testbench.sv
// Purpose: Self-checking bench for the lock-in reference timing.
// Assumes: Settle time shortened to 20 clocks.
// Notes: Rows cover register access after the first f-mode period check; further timing and loop tests follow.
`timescale 1ns/1ps
module testbench;
    import lrt_pkg::*;
    typedef struct {
        logic [7:0] wa;
        logic [31:0] wd;
        logic [7:0] ra;
        logic [31:0] mask;
        logic [31:0] exp;
    } lrt_row_type;
    localparam int LIMIT = 98000;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, other = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rd, got, e;
    logic signed [15:0] errl = 16'sh0000;
    logic [54:0] nv_load, nv_data;
    logic ack, nv_st, ref_en, smp_en, demod, modr, drive, ready;
    logic [2:0] fsel;
    logic [6:0] gain;
    logic signed [15:0] err_in, corr, mon, seen;
    int failures = 0, n_checks = 0, cycles = 0, n;
    lrt_row_type rows [11] = '{
        '{A_GAIN, 32'h64, A_GAIN, 32'h7f, 32'h50},
        '{A_GAIN, 32'h28, A_GAIN, 32'h7f, 32'h28},
        '{A_STEP, 32'h1, A_GAIN, 32'h7f, 32'h29},
        '{A_GAIN, 32'h50, A_GAIN, 32'h7f, 32'h50},
        '{A_STEP, 32'h1, A_GAIN, 32'h7f, 32'h50},
        '{A_STEP, 32'h2, A_GAIN, 32'h7f, 32'h4f},
        '{A_OFFSET, 32'h258, A_OFFSET, 32'hffff, 32'h1f4},
        '{A_OFFSET, 32'hfc18, A_OFFSET, 32'hffff, 32'hfe0c},
        '{A_OFFSET, 32'h64, A_OFFSET, 32'hffff, 32'h64},
        '{A_MODFREQ, 32'h12345678, A_MODFREQ, 32'hffffffff, 32'h0},
        '{8'h40, 32'hff, 8'h40, 32'hffffffff, 32'h0}
    };
    always #2.5 clock = ~clock;
    lrt_lockin_timing #(.SETTLE_CYCLES(20)) DUT (.clock(clock),
        .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd),
        .wb_ack_o(ack), .other_lock_active(other), .err_in(err_in),
        .nv_load_data(nv_load), .nv_store(nv_st), .nv_store_data(nv_data),
        .ref_clk_en(ref_en), .sample_clk_en(smp_en), .demod_ref(demod),
        .mod_ref(modr), .filt_select(fsel), .vga_gain_db(gain),
        .laser_corr(corr), .laser_drive(drive), .monitor_out(mon),
        .phase_ready(ready));
    lrt_far_model far (.clock(clock), .reset(reset), .sample_clk_en(smp_en),
        .err_level(errl), .laser_drive(drive), .laser_corr(corr),
        .err_in(err_in), .laser_seen(seen));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] x,
        input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic check_rng(input string nm, input int lo, input int hi,
        input int g);
        n_checks++;
        if (g < lo || g > hi) begin
            failures++;
            $display("unexpected %s: expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clock);
        while (ack !== 1'b1) @(posedge clock);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic ticks(input int k);
        repeat (k) begin
            @(posedge clock);
            while (smp_en !== 1'b1) @(posedge clock);
        end
        @(posedge clock);
    endtask
    // Counts clocks between two rising edges of the chosen reference.
    task automatic period(input logic m, output int p);
        int k;
        logic a, c;
        k = 0;
        p = 0;
        a = 1'b1;
        while (k < 2) begin
            @(posedge clock);
            c = m ? modr : demod;
            if (k == 1) p++;
            if (a === 1'b0 && c === 1'b1) k++;
            a = c;
        end
    endtask
    task automatic do_reset();
        reset <= 1'b1;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        nv_load = '0;
        nv_load[1:0] = 2'h1;
        nv_load[42:37] = 6'h05;
        nv_load[32:30] = 3'h6;
        nv_load[50:43] = 8'h10;
        nv_load[54:51] = 4'h8;
        do_reset();
        check("phase_ready", 32'h0, 32'(ready));
        while (ready !== 1'b1) @(posedge clock);
        period(1'b1, n);
        check_rng("mod_ref period f", 6103, 6104, n);
        foreach (rows[i]) begin
            wb(1'b1, rows[i].wa, rows[i].wd, got);
            wb(1'b0, rows[i].ra, 32'h0, got);
            check($sformatf("reg %h", rows[i].ra), rows[i].exp,
                got & rows[i].mask);
        end
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, A_FILT, 32'(c), got);
            @(posedge clock);
            e = c == 7 ? 32'h6 : 32'(c);
            check("filt_select", e, 32'(fsel));
        end
        wb(1'b1, A_CTRL, 32'h2, got);
        @(posedge clock);
        check("phase_ready", 32'h0, 32'(ready));
        while (ready !== 1'b1) @(posedge clock);
        period(1'b1, n);
        check_rng("mod_ref period 2f", 12207, 12208, n);
        wb(1'b1, A_CTRL, 32'h0, got);
        wb(1'b1, A_MODFREQ, 32'h01000000, got);
        wb(1'b0, A_MODFREQ, 32'h0, got);
        check("modfreq", 32'h01000000, got);
        repeat (40) @(posedge clock);
        check("phase_ready", 32'h0, 32'(ready));
        period(1'b1, n);
        check_rng("mod_ref period off", 256, 256, n);
        errl <= 16'sd100;
        wb(1'b1, A_OFFSET, 32'd30, got);
        wb(1'b1, A_LOOP, 32'h20, got);
        wb(1'b1, A_CTRL, 32'h19, got);
        ticks(3);
        check("laser_seen", 32'd140, 32'(seen));
        check("monitor_out", 32'd140, 32'(mon));
        wb(1'b1, A_CTRL, 32'h59, got);
        ticks(2);
        check("monitor_out", 32'd70, 32'(mon));
        wb(1'b1, A_CTRL, 32'h09, got);
        ticks(2);
        check("laser_drive", 32'h0, 32'(drive));
        wb(1'b1, A_CTRL, 32'h1d, got);
        ticks(4);
        check_rng("laser_corr", 141, 32767, int'(corr));
        other <= 1'b1;
        ticks(2);
        check("laser_drive", 32'h0, 32'(drive));
        other <= 1'b0;
        wb(1'b1, A_GAIN, 32'h28, got);
        wb(1'b1, A_CTRL, 32'h9d, got);
        check("saved gain", 32'h28, 32'(nv_data[13:7]));
        nv_load <= nv_data;
        do_reset();
        wb(1'b0, A_GAIN, 32'h0, got);
        check("reloaded gain", 32'h28, got & 32'h7f);
        finish_test();
    end
endmodule
